/* File: verilog/babs_top.sv */
// Node address and bit rate selection for the secondary bus port,
// plus communication, alarm and per-channel indicators.
// Assumes switches and status inputs are synchronous to sys_clk and
// that selection is made once after reset, as at power-on.
`timescale 1ns/1ps
module babs_top
#(
   parameter int HALF_SLOW_CYC = babs_pkg::HALF_SLOW_CYC,
   parameter int HALF_FAST_CYC = babs_pkg::HALF_FAST_CYC,
   parameter int ACT_HOLD_CYC  = babs_pkg::ACT_HOLD_CYC
)
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Variant and switches
   input  wire babs_pkg::babs_variant_e variant,
   input  wire logic [6:0]              addrSwitch,
   input  wire logic [3:0]              rateConfigCode,
   // Nonvolatile memory contents
   input  wire logic [6:0]              nvAddress,
   input  wire logic [3:0]              nvRateCode,
   // Software writes
   input  wire logic                    swAddrWe,
   input  wire logic [6:0]              swAddrData,
   input  wire logic                    swRateWe,
   input  wire logic [3:0]              swRateData,
   // Bus status
   input  wire logic                    commActivity,
   input  wire logic                    pbAddressed,
   input  wire logic                    pbCyclic,
   input  wire logic                    pbInterrupted,
   input  wire logic                    pbParamError,
   // Alarms and channels
   input  wire logic                    alarmConfigured,
   input  wire logic [2:0]              alarmActive,
   input  wire logic [15:0]             outDefined,
   input  wire logic [15:0]             outState,
   input  wire logic [3:0]              chanIsInput,
   input  wire logic [3:0]              inLevel,
   // Selected port settings
   output logic [6:0]                   nodeAddr,
   output logic [3:0]                   rateCode,
   output logic [19:0]                  baudRate,
   output logic                         portEnable,
   output logic                         autoBaud,
   output logic                         configDone,
   // Software readback
   output logic [6:0]                   swAddrRead,
   output logic [3:0]                   swRateRead,
   output logic                         addrFromSwitch,
   output logic                         rateFromSwitch,
   // Indicators
   output logic                         commActivityIndicator,
   output logic [2:0]                   alarmIndicators,
   output logic [15:0]                  outIndicators
);

   // ====================================================================
   // State
   typedef struct packed
   {
      babs_pkg::babs_phase_e      phase;
      logic [6:0]                 nodeAddr;
      logic [3:0]                 rateCode;
      logic [19:0]                baud;
      logic                       portEn;
      logic                       autoBaud;
      logic                       addrFromSw;
      logic                       rateFromSw;
      logic [6:0]                 addrRead;
      logic [3:0]                 rateRead;
      logic [babs_pkg::CNT_W-1:0] holdCnt;
      logic                       commLed;
      logic [2:0]                 alarmLed;
      logic [15:0]                outLed;
   } babs_state_s;

   babs_state_s st_r;
   babs_state_s st_nxt;
   logic        slowPhase;
   logic        fastPhase;

   localparam logic [babs_pkg::CNT_W-1:0] HOLD_LOAD =
      babs_pkg::CNT_W'(ACT_HOLD_CYC);

   // ====================================================================
   // Blink sources
   babs_blink #(.HALF_CYC(HALF_SLOW_CYC)) u_slow
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .phase   (slowPhase)
   );

   babs_blink #(.HALF_CYC(HALF_FAST_CYC)) u_fast
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .phase   (fastPhase)
   );

   // ====================================================================
   // Rate table, returns {valid, baud}
   function automatic logic [20:0] rateLookup
   (
      input babs_pkg::babs_variant_e v,
      input logic [3:0]              c
   );
      logic [20:0] r;
      r = {1'b0, babs_pkg::BD_NONE};
      if (v == babs_pkg::VAR_SERIAL)
      begin
         case (c)
            4'h1:    r = {1'b1, babs_pkg::BD_2400};
            4'h2:    r = {1'b1, babs_pkg::BD_4800};
            4'h3:    r = {1'b1, babs_pkg::BD_9600};
            4'h4:    r = {1'b1, babs_pkg::BD_19200};
            default: r = {1'b0, babs_pkg::BD_NONE};
         endcase
      end
      else if (v == babs_pkg::VAR_CAN)
      begin
         case (c)
            4'h1:    r = {1'b1, babs_pkg::BD_20K};
            4'h2:    r = {1'b1, babs_pkg::BD_125K};
            4'h3:    r = {1'b1, babs_pkg::BD_500K};
            4'h4:    r = {1'b1, babs_pkg::BD_1M};
            4'h5:    r = {1'b1, babs_pkg::BD_10K};
            4'h6:    r = {1'b1, babs_pkg::BD_50K};
            4'h7:    r = {1'b1, babs_pkg::BD_250K};
            4'h8:    r = {1'b1, babs_pkg::BD_800K};
            default: r = {1'b0, babs_pkg::BD_NONE};
         endcase
      end
      else if (v == babs_pkg::VAR_DNET)
      begin
         case (c)
            4'h3:    r = {1'b1, babs_pkg::BD_500K};
            4'h7:    r = {1'b1, babs_pkg::BD_250K};
            default: r = {1'b1, babs_pkg::BD_125K};
         endcase
      end
      else
      begin
         r = {1'b1, babs_pkg::BD_NONE};
      end
      return r;
   endfunction

   // ====================================================================
   // Next state
   always_comb
   begin
      logic [20:0] lk;
      logic        swAddr;
      lk     = '0;
      swAddr = 1'b0;
      st_nxt = st_r;
      if (st_r.phase == babs_pkg::PH_LOAD)
      begin
         swAddr = (addrSwitch != babs_pkg::ADDR_SW_NV) &&
                  (addrSwitch <= babs_pkg::ADDR_SW_MAX);
         st_nxt.addrFromSw = swAddr;
         st_nxt.nodeAddr   = swAddr ? addrSwitch : nvAddress;
         st_nxt.rateFromSw = rateConfigCode != babs_pkg::RATE_SW_NV;
         st_nxt.rateCode   = st_nxt.rateFromSw ? rateConfigCode
                                               : nvRateCode;
         st_nxt.phase      = babs_pkg::PH_RUN;
      end
      else
      begin
         if (swAddrWe && !st_r.addrFromSw)
            st_nxt.nodeAddr = swAddrData;
         if (swRateWe && !st_r.rateFromSw)
            st_nxt.rateCode = swRateData;
      end
      lk              = rateLookup(variant, st_nxt.rateCode);
      st_nxt.baud     = lk[19:0];
      st_nxt.portEn   = lk[20];
      st_nxt.autoBaud = variant == babs_pkg::VAR_PBUS;
      st_nxt.addrRead = st_nxt.addrFromSw ? babs_pkg::ADDR_RST
                                          : st_nxt.nodeAddr;
      st_nxt.rateRead = st_nxt.rateFromSw ? babs_pkg::RATE_RST
                                          : st_nxt.rateCode;

      // Traffic stretch keeps short bursts visible
      if (commActivity)
         st_nxt.holdCnt = HOLD_LOAD;
      else if (st_r.holdCnt != '0)
         st_nxt.holdCnt = st_r.holdCnt - 1'b1;

      if (variant == babs_pkg::VAR_PBUS)
      begin
         if (!pbAddressed)
            st_nxt.commLed = 1'b0;
         else if (pbParamError)
            st_nxt.commLed = fastPhase;
         else if (pbInterrupted)
            st_nxt.commLed = slowPhase;
         else
            st_nxt.commLed = pbCyclic;
      end
      else
      begin
         st_nxt.commLed = (st_r.holdCnt != '0) && fastPhase;
      end

      st_nxt.alarmLed = alarmConfigured ? alarmActive : 3'h0;
      for (int i = 0; i < babs_pkg::NUM_OUT_CH; i++)
         st_nxt.outLed[i] = outDefined[i] & outState[i];
      for (int j = 0; j < 4; j++)
         if (chanIsInput[j])
            st_nxt.outLed[babs_pkg::FIRST_INPUT_CH + j] = inLevel[j];
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r          <= '0;
         st_r.phase    <= babs_pkg::PH_LOAD;
         st_r.nodeAddr <= babs_pkg::ADDR_RST;
         st_r.rateCode <= babs_pkg::RATE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ====================================================================
   // Outputs
   assign nodeAddr              = st_r.nodeAddr;
   assign rateCode              = st_r.rateCode;
   assign baudRate              = st_r.baud;
   assign portEnable            = st_r.portEn;
   assign autoBaud              = st_r.autoBaud;
   assign configDone            = st_r.phase == babs_pkg::PH_RUN;
   assign swAddrRead            = st_r.addrRead;
   assign swRateRead            = st_r.rateRead;
   assign addrFromSwitch        = st_r.addrFromSw;
   assign rateFromSwitch        = st_r.rateFromSw;
   assign commActivityIndicator = st_r.commLed;
   assign alarmIndicators       = st_r.alarmLed;
   assign outIndicators         = st_r.outLed;

   // ====================================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // The release edge still loads reset values, so it is kept out
   wire inLoad = !rst && st_r.phase == babs_pkg::PH_LOAD;

   property p_addr_switch;
      inLoad && addrSwitch != 7'h00 && addrSwitch <= 7'h63
      |=> nodeAddr == $past(addrSwitch) && addrFromSwitch;
   endproperty
   a_addr_switch: assert property (p_addr_switch)
      else $error("switch address not applied");

   property p_addr_nv;
      inLoad && addrSwitch == 7'h00 |=> nodeAddr == $past(nvAddress);
   endproperty
   a_addr_nv: assert property (p_addr_nv)
      else $error("stored address not applied");

   property p_addr_locked;
      configDone && addrFromSwitch && swAddrWe
      |=> $stable(nodeAddr) ##0 swAddrRead == 7'h00;
   endproperty
   a_addr_locked: assert property (p_addr_locked)
      else $error("switch address reachable by software");

   property p_rate_sw_write;
      configDone && !rateFromSwitch && swRateWe
      |=> rateCode == $past(swRateData) ##0 swRateRead == rateCode;
   endproperty
   a_rate_sw_write: assert property (p_rate_sw_write)
      else $error("software rate write lost");

   property p_serial_table;
      configDone && variant == babs_pkg::VAR_SERIAL && rateCode == 4'h4
      |-> baudRate == 20'h04B00 && portEnable;
   endproperty
   a_serial_table: assert property (p_serial_table)
      else $error("serial rate table wrong");

   property p_can_table;
      configDone && variant == babs_pkg::VAR_CAN && rateCode == 4'h8
      |-> baudRate == 20'hC3500;
   endproperty
   a_can_table: assert property (p_can_table)
      else $error("CAN rate table wrong");

   property p_pbus_auto;
      !rst && variant == babs_pkg::VAR_PBUS ##1
      variant == babs_pkg::VAR_PBUS |-> autoBaud;
   endproperty
   a_pbus_auto: assert property (p_pbus_auto)
      else $error("auto rate not flagged");

   property p_dnet_fallback;
      configDone && variant == babs_pkg::VAR_DNET && rateCode == 4'h1
      |-> baudRate == 20'h1E848;
   endproperty
   a_dnet_fallback: assert property (p_dnet_fallback)
      else $error("device net fallback wrong");

   property p_pbus_dark;
      variant == babs_pkg::VAR_PBUS && !pbAddressed
      |=> !commActivityIndicator;
   endproperty
   a_pbus_dark: assert property (p_pbus_dark)
      else $error("indicator lit before addressing");

   property p_pbus_steady;
      variant == babs_pkg::VAR_PBUS && pbAddressed && pbCyclic &&
      !pbInterrupted && !pbParamError |=> commActivityIndicator;
   endproperty
   a_pbus_steady: assert property (p_pbus_steady)
      else $error("indicator not steady in exchange");

   property p_alarm;
      !rst && alarmConfigured && alarmActive[1] |=> alarmIndicators[1];
   endproperty
   a_alarm: assert property (p_alarm)
      else $error("alarm indicator not lit");

   property p_input_led;
      !rst && chanIsInput[3] && inLevel[3] |=> outIndicators[15];
   endproperty
   a_input_led: assert property (p_input_led)
      else $error("input level not shown");

   property p_serial_off;
      configDone && variant == babs_pkg::VAR_SERIAL && rateCode == 4'h5
      |-> !portEnable;
   endproperty
   a_serial_off: assert property (p_serial_off)
      else $error("invalid serial rate left port on");

   c_addr_sw: cover property (inLoad && addrSwitch == 7'h2A);
   c_pb_err:  cover property (pbAddressed && pbParamError ##1
                              commActivityIndicator);
   c_traffic: cover property (commActivity ##1 commActivityIndicator);

endmodule

/* File: verilog/babs_pkg.sv */
// Shared constants and types for the bus address and baud select block.
// Assumes a 10 MHz system clock and a synchronous, active-high reset.
package babs_pkg;

   // ====================================================================
   // Port variants and load phases
   typedef enum logic [1:0] {VAR_SERIAL, VAR_CAN, VAR_DNET, VAR_PBUS}
      babs_variant_e;
   typedef enum logic [0:0] {PH_LOAD, PH_RUN} babs_phase_e;

   // ====================================================================
   // Switch and field limits
   localparam logic [6:0] ADDR_SW_NV  = 7'h00;
   localparam logic [6:0] ADDR_SW_MAX = 7'h63;
   localparam logic [3:0] RATE_SW_NV  = 4'h0;
   localparam logic [6:0] ADDR_RST    = 7'h00;
   localparam logic [3:0] RATE_RST    = 4'h0;
   localparam int         FIRST_INPUT_CH = 12;
   localparam int         NUM_OUT_CH     = 16;
   localparam int         NUM_ALARMS     = 3;

   // ====================================================================
   // Bit rates in baud
   localparam logic [19:0] BD_2400   = 20'h00960;
   localparam logic [19:0] BD_4800   = 20'h012C0;
   localparam logic [19:0] BD_9600   = 20'h02580;
   localparam logic [19:0] BD_19200  = 20'h04B00;
   localparam logic [19:0] BD_10K    = 20'h02710;
   localparam logic [19:0] BD_20K    = 20'h04E20;
   localparam logic [19:0] BD_50K    = 20'h0C350;
   localparam logic [19:0] BD_125K   = 20'h1E848;
   localparam logic [19:0] BD_250K   = 20'h3D090;
   localparam logic [19:0] BD_500K   = 20'h7A120;
   localparam logic [19:0] BD_800K   = 20'hC3500;
   localparam logic [19:0] BD_1M     = 20'hF4240;
   localparam logic [19:0] BD_NONE   = 20'h00000;

   // ====================================================================
   // Timing
   localparam int CLK_HZ      = 10_000_000;
   localparam int SLOW_BLINK_HZ = 2;
   localparam int FAST_BLINK_HZ = 4;
   localparam int HALF_SLOW_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
   localparam int HALF_FAST_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
   localparam int ACT_HOLD_CYC  = 2 * HALF_FAST_CYC;
   localparam int CNT_W         = 24;

endpackage

/* File: verilog/babs_blink.sv */
// Free-running square wave with 50 percent duty for indicator blinking.
// Assumes HALF_CYC fits in babs_pkg::CNT_W bits and is at least one.
`timescale 1ns/1ps
module babs_blink
#(
   parameter int HALF_CYC = babs_pkg::HALF_SLOW_CYC
)
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Square wave
   output logic      phase
);

   // ====================================================================
   // State
   typedef struct packed
   {
      logic [babs_pkg::CNT_W-1:0] cnt;
      logic                       phase;
   } babs_blink_s;

   babs_blink_s st_r;
   babs_blink_s st_nxt;

   localparam logic [babs_pkg::CNT_W-1:0] LAST =
      babs_pkg::CNT_W'(HALF_CYC - 1);

   always_comb
   begin
      st_nxt = st_r;
      if (st_r.cnt >= LAST)
      begin
         st_nxt.cnt   = '0;
         st_nxt.phase = ~st_r.phase;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign phase = st_r.phase;

endmodule

/* File: tb/babs_master_model.sv */
// Behavioural fieldbus master driving the block's bus status inputs.
// Assumes the bench changes busState and xferReq just after sys_clk rises.
`timescale 1ns/1ps
module babs_master_model
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Bench commands
   input  wire logic [2:0] busState,
   input  wire logic       xferReq,
   // Status toward the block
   output logic            commActivity,
   output logic            pbAddressed,
   output logic            pbCyclic,
   output logic            pbInterrupted,
   output logic            pbParamError
);
   typedef struct packed
   {
      logic act;
      logic adr;
      logic cyc;
      logic intr;
      logic perr;
   } babs_mstate_s;

   babs_mstate_s st_r;
   babs_mstate_s st_nxt;

   // ====================================================================
   // Next state, one register stage like a real line receiver
   always_comb
   begin
      st_nxt = '0;
      st_nxt.act = xferReq;
      st_nxt.adr = busState != 3'h0;
      st_nxt.cyc = busState == 3'h1;
      st_nxt.intr = busState == 3'h2;
      st_nxt.perr = busState == 3'h3;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign commActivity  = st_r.act;
   assign pbAddressed   = st_r.adr;
   assign pbCyclic      = st_r.cyc;
   assign pbInterrupted = st_r.intr;
   assign pbParamError  = st_r.perr;
endmodule

/* File: tb/tb_bus_address_baud_select.sv */
// Self-checking bench for babs_top beside a behavioural bus master.
// Assumes shortened blink parameters so indicator timing runs short.
`timescale 1ns/1ps
module tb_bus_address_baud_select;
   localparam int HS = 8;
   localparam int HF = 4;
   localparam int AH = 8;

   // ====================================================================
   // Stimulus and observed signals
   logic                    sys_clk = 1'b0;
   logic                    rst = 1'b1;
   babs_pkg::babs_variant_e variant = babs_pkg::VAR_SERIAL;
   logic [6:0]              addrSwitch = 7'h00, nvAddress = 7'h00;
   logic [6:0]              swAddrData = 7'h00;
   logic [3:0]              rateConfigCode = 4'h0, nvRateCode = 4'h0;
   logic [3:0]              swRateData = 4'h0;
   logic                    swAddrWe = 1'b0, swRateWe = 1'b0;
   logic                    alarmConfigured = 1'b0, xferReq = 1'b0;
   logic [2:0]              alarmActive = 3'h0, busState = 3'h0;
   logic [15:0]             outDefined = 16'h0000, outState = 16'h0000;
   logic [3:0]              chanIsInput = 4'h0, inLevel = 4'h0;
   logic                    commActivity, pbAddressed, pbCyclic;
   logic                    pbInterrupted, pbParamError;
   logic [6:0]              nodeAddr, swAddrRead;
   logic [3:0]              rateCode, swRateRead;
   logic [19:0]             baudRate;
   logic                    portEnable, autoBaud, configDone;
   logic                    addrFromSwitch, rateFromSwitch;
   logic                    commActivityIndicator;
   logic [2:0]              alarmIndicators;
   logic [15:0]             outIndicators;
   int                      fails = 0;
   int                      checked = 0;
   int                      seed = 32344;
   logic [6:0]              bnd [5] = '{7'h00, 7'h01, 7'h63, 7'h64, 7'h7F};

   babs_top #(.HALF_SLOW_CYC(HS), .HALF_FAST_CYC(HF), .ACT_HOLD_CYC(AH))
   dut_u (.sys_clk, .rst, .variant, .addrSwitch, .rateConfigCode,
      .nvAddress, .nvRateCode, .swAddrWe, .swAddrData, .swRateWe,
      .swRateData, .commActivity, .pbAddressed, .pbCyclic, .pbInterrupted,
      .pbParamError, .alarmConfigured, .alarmActive, .outDefined,
      .outState, .chanIsInput, .inLevel, .nodeAddr, .rateCode, .baudRate,
      .portEnable, .autoBaud, .configDone, .swAddrRead, .swRateRead,
      .addrFromSwitch, .rateFromSwitch, .commActivityIndicator,
      .alarmIndicators, .outIndicators);

   babs_master_model master_u (.sys_clk, .rst, .busState, .xferReq,
      .commActivity, .pbAddressed, .pbCyclic, .pbInterrupted, .pbParamError);

   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   // ====================================================================
   // Reference model and helpers
   function automatic int eBaud(int v, int c);
      int ser [5] = '{0, 2400, 4800, 9600, 19200};
      int can [9] = '{0, 20000, 125000, 500000, 1000000, 10000, 50000,
                      250000, 800000};
      if (v == 0)
         return (c < 5) ? ser[c] : 0;
      if (v == 1)
         return (c < 9) ? can[c] : 0;
      if (v == 2)
         return (c == 3) ? 500000 : (c == 7) ? 250000 : 125000;
      return 0;
   endfunction

   function automatic logic [15:0] eOut();
      logic [15:0] r;
      r = outDefined & outState;
      for (int i = 12; i < 16; i++)
         if (chanIsInput[i-12])
            r[i] = inLevel[i-12];
      return r;
   endfunction

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("Counts: %0d checked, %0d fails", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Leaves the bench just after load edge 1 has settled
   task automatic doReset(int n);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic meas(int n, output int hi, output int tg);
      logic p;
      hi = 0;
      tg = 0;
      @(posedge sys_clk);
      #1;
      p = commActivityIndicator;
      repeat (n)
      begin
         @(posedge sys_clk);
         #1;
         hi += int'(commActivityIndicator === 1'b1);
         tg += int'(commActivityIndicator !== p);
         p = commActivityIndicator;
      end
   endtask

   task automatic cfgCheck(int v);
      logic sw;
      logic rs;
      int   a;
      int   c;
      int   b;
      sw = addrSwitch >= 7'h01 && addrSwitch <= 7'h63;
      rs = rateConfigCode != 4'h0;
      a = sw ? int'(addrSwitch) : int'(nvAddress);
      c = rs ? int'(rateConfigCode) : int'(nvRateCode);
      b = eBaud(v, c);
      chk("configDone", 32'(configDone), 32'h1);
      chk("nodeAddr", 32'(nodeAddr), 32'(a));
      chk("addrFromSwitch", 32'(addrFromSwitch), 32'(sw));
      chk("swAddrRead", 32'(swAddrRead), 32'(sw ? 0 : a));
      chk("rateFromSwitch", 32'(rateFromSwitch), 32'(rs));
      chk("baudRate", 32'(baudRate), 32'(b));
      chk("portEnable", 32'(portEnable), 32'(v == 3 || b != 0));
      chk("autoBaud", 32'(autoBaud), 32'(v == 3));
      chk("swRateRead", 32'(swRateRead), 32'(rs ? 0 : c));
      if (v < 2)
         chk("rateCode", 32'(rateCode), 32'(c));
   endtask

   // ====================================================================
   // Main sequence
   initial
   begin
      int hi;
      int tg;
      int ea;
      int et;
      int eh;
      for (int v = 0; v < 4; v++)
         for (int k = 0; k < 16; k++)
         begin
            @(posedge sys_clk);
            variant <= babs_pkg::babs_variant_e'(v);
            rateConfigCode <= 4'(k);
            nvRateCode <= 4'($random(seed));
            addrSwitch <= (k < 5) ? bnd[k] : 7'($random(seed));
            nvAddress <= 7'($random(seed));
            doReset((v == 0 && k == 0) ? 12 : 2);
            cfgCheck(v);
         end
      $display("Test load table done");
      @(posedge sys_clk);
      variant <= babs_pkg::VAR_CAN;
      addrSwitch <= 7'h00;
      rateConfigCode <= 4'h0;
      nvAddress <= 7'h05;
      nvRateCode <= 4'h1;
      doReset(2);
      @(posedge sys_clk);
      swRateWe <= 1'b1;
      swRateData <= 4'h3;
      @(posedge sys_clk);
      swRateData <= 4'h8;
      swAddrWe <= 1'b1;
      swAddrData <= 7'h2A;
      addrSwitch <= 7'h09;
      #1;
      chk("baudRate", 32'(baudRate), 32'(eBaud(1, 3)));
      @(posedge sys_clk);
      swRateWe <= 1'b0;
      swAddrWe <= 1'b0;
      #1;
      chk("rateCode", 32'(rateCode), 32'h8);
      chk("baudRate", 32'(baudRate), 32'(eBaud(1, 8)));
      chk("swRateRead", 32'(swRateRead), 32'h8);
      chk("nodeAddr", 32'(nodeAddr), 32'h2A);
      chk("swAddrRead", 32'(swAddrRead), 32'h2A);
      @(posedge sys_clk);
      swRateWe <= 1'b1;
      swRateData <= 4'h9;
      @(posedge sys_clk);
      swRateWe <= 1'b0;
      #1;
      chk("portEnable", 32'(portEnable), 32'h0);
      @(posedge sys_clk);
      addrSwitch <= 7'h11;
      rateConfigCode <= 4'h2;
      doReset(2);
      @(posedge sys_clk);
      swAddrWe <= 1'b1;
      swRateWe <= 1'b1;
      swAddrData <= 7'h20;
      swRateData <= 4'h5;
      addrSwitch <= 7'h22;
      @(posedge sys_clk);
      swAddrWe <= 1'b0;
      swRateWe <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("nodeAddr", 32'(nodeAddr), 32'h11);
      chk("swAddrRead", 32'(swAddrRead), 32'h0);
      chk("swRateRead", 32'(swRateRead), 32'h0);
      chk("baudRate", 32'(baudRate), 32'(eBaud(1, 2)));
      $display("Test software access done");
      repeat (24)
      begin
         @(posedge sys_clk);
         alarmConfigured <= 1'($random(seed));
         alarmActive <= 3'($random(seed));
         outDefined <= 16'($random(seed));
         outState <= 16'($random(seed));
         chanIsInput <= 4'($random(seed));
         inLevel <= 4'($random(seed));
         @(posedge sys_clk);
         #1;
         ea = alarmConfigured ? int'(alarmActive) : 0;
         chk("alarms", 32'(alarmIndicators), 32'(ea));
         chk("outputs", 32'(outIndicators), 32'(eOut()));
      end
      $display("Test indicators done");
      @(posedge sys_clk);
      variant <= babs_pkg::VAR_PBUS;
      doReset(2);
      for (int s = 0; s < 4; s++)
      begin
         @(posedge sys_clk);
         busState <= 3'(s);
         repeat (3) @(posedge sys_clk);
         meas(32, hi, tg);
         et = (s == 2) ? 32 / HS : (s == 3) ? 32 / HF : 0;
         eh = (s == 0) ? 0 : (s == 1) ? 32 : 16;
         chk("toggles", tg, et);
         chk("highs", hi, eh);
      end
      @(posedge sys_clk);
      variant <= babs_pkg::VAR_CAN;
      busState <= 3'h0;
      doReset(2);
      @(posedge sys_clk);
      xferReq <= 1'b1;
      @(posedge sys_clk);
      xferReq <= 1'b0;
      meas(10, hi, tg);
      chk("activity", 32'(hi > 0), 32'h1);
      repeat (4) @(posedge sys_clk);
      meas(16, hi, tg);
      chk("idle", 32'(hi), 32'h0);
      $display("Test comm indicator done");
      end_of_test();
   end

   // Hang guard, far beyond the expected run of about six hundred cycles
   initial
   begin
      #(20000 * 100);
      fails++;
      $display("[ERR] watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule
